// ===== rtl/mdc_regs.vh
/*
  register offsets, field positions, reset values, limits and timing for the
  delay phase controller. assumes byte-wide registers on the serial port.
*/
`ifndef MDC_REGS_VH
`define MDC_REGS_VH

`define MDC_OFF_BOOST          7'h24
`define MDC_OFF_DCC            7'h25
`define MDC_OFF_CTRL           7'h26
`define MDC_OFF_DLY_LO         7'h27
`define MDC_OFF_DLY_HI         7'h28
`define MDC_OFF_TOL_GUARD      7'h29
`define MDC_OFF_STATUS         7'h2a

`define MDC_RST_BOOST          8'h00
`define MDC_RST_DCC            8'h00
`define MDC_RST_CTRL           8'h00
`define MDC_RST_DLY_LO         8'h00
`define MDC_RST_DLY_HI         8'h00
`define MDC_RST_TOL_GUARD      8'h00

`define MDC_CTRL_EN_BIT        0
`define MDC_CTRL_SLOPE_BIT     1
`define MDC_CTRL_READ_BIT      3
`define MDC_CTRL_MODE_LSB      4
`define MDC_BOOST_LSB          4
`define MDC_DCC_BIT            7
`define MDC_DLY_LSB_BIT        7
`define MDC_DIR_LSB            5
`define MDC_TGT_LSB            0
`define MDC_TOL_BIT            7
`define MDC_FAIL_BIT           5
`define MDC_GUARD_LSB          0
`define MDC_STAT_LOCK_BIT      0
`define MDC_STAT_LOST_BIT      1

`define MDC_MODE_SRCH_TRACK    2'h0
`define MDC_MODE_TRACK         2'h1
`define MDC_MODE_SRCH          2'h2
`define MDC_DIR_DOWN           2'h0
`define MDC_DIR_UP             2'h1

`define MDC_DELAY_MAX          9'h1b0
`define MDC_SLOPE_DLY_MAX      9'h1af
`define MDC_PHASE_MAX          5'h10
`define MDC_SLOPE_DEV          5'h02
`define MDC_TOL_LOOSE          5'h02
`define MDC_LOCK_DEV           5'h05

`define MDC_CLK_PERIOD_NS      100
`define MDC_SETTLE_NS          1000

`endif

// ===== rtl/mdc_spi_slave.v
/*
  serial configuration port: 8-bit instruction {read, addr[6:0]} then 8 data
  bits, msb first, sampled on sclk rise, read msb driven after the eighth rise, later bits after sclk fall.
  assumes sclk is at most one eighth of clk; all pins are synchronised here.
*/
`timescale 1ns/10ps
module mdc_spi_slave (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_sdi,
  output reg        spi_sdo,
  output reg        spi_sdo_oe,
  output reg  [6:0] addr,
  output reg  [7:0] wdata,
  output reg        wr_stb,
  input  wire [7:0] rdata
);
  reg  [2:0] sclk_sy;
  reg  [1:0] cs_sy;
  reg  [1:0] sdi_sy;
  reg  [4:0] cnt;
  reg  [6:0] sh;
  reg  [6:0] out_sh;
  reg        rd_op;
  reg        load;
  wire       rise;
  wire       fall;

  assign rise = sclk_sy[1] & ~sclk_sy[2];
  assign fall = ~sclk_sy[1] & sclk_sy[2];

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_sy    <= 3'h0;
      cs_sy      <= 2'h3;
      sdi_sy     <= 2'h0;
      cnt        <= 5'h00;
      sh         <= 7'h00;
      out_sh     <= 7'h00;
      rd_op      <= 1'b0;
      load       <= 1'b0;
      addr       <= 7'h00;
      wdata      <= 8'h00;
      wr_stb     <= 1'b0;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      sclk_sy <= {sclk_sy[1:0], spi_sclk};
      cs_sy   <= {cs_sy[0], spi_cs_n};
      sdi_sy  <= {sdi_sy[0], spi_sdi};
      wr_stb  <= 1'b0;
      load    <= 1'b0;
      if (cs_sy[1])
      begin
        cnt        <= 5'h00;
        spi_sdo_oe <= 1'b0;
      end
      else
      begin
        if (rise && cnt < 5'h10)
        begin
          sh  <= {sh[5:0], sdi_sy[1]};
          cnt <= cnt + 5'h01;
          if (cnt == 5'h07)
          begin
            rd_op <= sh[6];
            addr  <= {sh[5:0], sdi_sy[1]};
            load  <= 1'b1;
          end
          if (cnt == 5'h0f)
          begin
            wdata  <= {sh[6:0], sdi_sy[1]};
            wr_stb <= ~rd_op;
          end
        end
        // rdata follows addr combinationally, so load one cycle after addr settles
        if (load)
        begin
          spi_sdo    <= rdata[7];
          out_sh     <= rdata[6:0];
          spi_sdo_oe <= rd_op;
        end
        else if (fall && spi_sdo_oe && cnt > 5'h08)
        begin
          spi_sdo <= out_sh[6];
          out_sh  <= {out_sh[5:0], 1'b0};
        end
      end
    end
  end
endmodule

// ===== rtl/mdc_phase_filter.v
/*
  brings the phase comparator word into the clock domain and reports it only
  once it has held still for the settle time after a restart.
  assumes the comparator output is asynchronous to clk.
*/
`timescale 1ns/10ps
`include "mdc_regs.vh"
module mdc_phase_filter #(
  parameter SETTLE_NS = `MDC_SETTLE_NS,
  parameter CLK_NS    = `MDC_CLK_PERIOD_NS
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire [4:0] phase_pin,
  input  wire       restart,
  output reg  [4:0] phase,
  output reg        phase_valid
);
  localparam SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam [7:0] SETTLE_MAX = (SETTLE_CYC < 1) ? 8'h01 : SETTLE_CYC[7:0];

  reg  [4:0] sy1;
  reg  [4:0] sy2;
  reg  [7:0] cnt;

  // a multi-bit word is caught per bit; the stability count hides bit skew
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sy1         <= 5'h00;
      sy2         <= 5'h00;
      phase       <= 5'h00;
      cnt         <= 8'h00;
      phase_valid <= 1'b0;
    end
    else
    begin
      sy1   <= phase_pin;
      sy2   <= sy1;
      phase <= sy2;
      if (restart || sy2 != phase)
      begin
        cnt         <= 8'h00;
        phase_valid <= 1'b0;
      end
      else if (cnt < SETTLE_MAX)
        cnt <= cnt + 8'h01;
      else
        phase_valid <= 1'b1;
    end
  end
endmodule

// ===== rtl/mdc_controller.v
/*
  delay phase controller: register file on the serial port, phase search with
  slope check, single-step tracking and lock status.
  assumes a settled comparator phase word and an analog delay line fed by
  delay_line_value.
// Notes on behaviour
// RULE1: controller runs only while control bit 0 at delay_controller_control is high.
// RULE2: software should enable boost and duty correction before enabling.
// RULE3: mode field: 0 search then track, 1 track only, 2 search only.
// RULE4: start delay lsb from delay_low_direction_phase bit 7, upper bits from delay_value_high.
// RULE5: software keeps delay at or below 432, ideally near 216.
// RULE6: target phase is 5 bits at delay_low_direction_phase, never above 16.
// RULE7: on target hit, measure slope and compare with programmed slope bit.
// RULE8: tolerance bit: 0 accepts within two of target, 1 needs exact.
// RULE9: direction field: 0 down, 1 up, 2 alternating.
// RULE10: alternate until one guard band, then opposite only, then alternate inside.
// RULE11: endpoint means failed search; fail bit chooses continue or reset.
// RULE12: slope: step up then down until phase moves 2, or limits hit.
// RULE13: slope valid only if up and down phases straddle the target.
// RULE14: tracking steps delay by one per sample along programmed slope.
// RULE15: status bit 0 lock; beyond five steps clear it, set lost if locked.
// RULE16: on lock loss either stay tracking or restart the search.
// RULE17: read bit makes delay and phase fields show locked values.
// RULE18: typical lock takes about 180K converter cycles.
// RULE19: readback captured once per rising read bit, not continuously.
// RULE20: software picks delay for phase 6 on negative slope.
// RULE21: search-only and track-only run only while enabled; track starts at start delay.
// RULE22: clearing enable idles the controller and holds the delay.
*/
`timescale 1ns/10ps
`include "mdc_regs.vh"
module mdc_controller #(
  parameter SETTLE_NS = `MDC_SETTLE_NS
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_sdi,
  output wire       spi_sdo,
  output wire       spi_sdo_oe,
  input  wire [4:0] phase_pin,
  output reg  [8:0] delay_line_value,
  output reg  [1:0] boost_level,
  output reg        dcc_enable,
  output reg        delay_locked,
  output reg        delay_lock_lost
);
  localparam S_IDLE  = 7'h01;
  localparam S_INIT  = 7'h02;
  localparam S_SRCH  = 7'h04;
  localparam S_SUP   = 7'h08;
  localparam S_SDN   = 7'h10;
  localparam S_TRACK = 7'h20;
  localparam S_HOLD  = 7'h40;

  reg  [7:0] reg_boost;
  reg  [7:0] reg_dcc;
  reg  [7:0] reg_ctrl;
  reg  [7:0] reg_dly_lo;
  reg  [7:0] reg_dly_hi;
  reg  [7:0] reg_tol;
  reg  [8:0] rb_delay;
  reg  [4:0] rb_phase;
  reg        read_q;
  reg  [7:0] rdata;
  reg  [6:0] state;
  reg  [8:0] up_d;
  reg  [8:0] dn_d;
  reg  [8:0] center;
  reg  [4:0] p0;
  reg  [4:0] p_up;
  reg        alt;
  reg        restart;
  reg        en_q;
  reg        can_up;
  reg        can_dn;
  reg        step_ok;
  reg        step_up;
  wire [6:0] addr;
  wire [7:0] wdata;
  wire       wr_stb;
  wire [4:0] phase;
  wire       phase_valid;
  wire       phase_valid_raw;
  wire       enable;
  wire       slope_pos;
  wire [1:0] mode;
  wire [1:0] dir;
  wire [4:0] target;
  wire [4:0] guard;
  wire       exact;
  wire       fail_rst;
  wire [8:0] start_d;
  wire       hit;
  wire       up_g;
  wire       dn_g;
  wire [4:0] dev;

  function [4:0] absdiff;
    input [4:0] a;
    input [4:0] b;
    begin
      absdiff = (a > b) ? a - b : b - a;
    end
  endfunction

  mdc_spi_slave u_spi (
    .clk        (clk),
    .arst_n     (arst_n),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .addr       (addr),
    .wdata      (wdata),
    .wr_stb     (wr_stb),
    .rdata      (rdata)
  );

  mdc_phase_filter #(.SETTLE_NS(SETTLE_NS), .CLK_NS(`MDC_CLK_PERIOD_NS)) u_phase (
    .clk         (clk),
    .arst_n      (arst_n),
    .phase_pin   (phase_pin),
    .restart     (restart),
    .phase       (phase),
    .phase_valid (phase_valid_raw)
  );

  // the filter drops valid one cycle after a restart; mask that cycle so a stale phase never steps twice
  assign phase_valid = phase_valid_raw & ~restart;

  assign enable    = reg_ctrl[`MDC_CTRL_EN_BIT];
  assign slope_pos = reg_ctrl[`MDC_CTRL_SLOPE_BIT];
  assign mode      = reg_ctrl[`MDC_CTRL_MODE_LSB +: 2];
  assign dir       = reg_dly_lo[`MDC_DIR_LSB +: 2];
  assign target    = reg_dly_lo[`MDC_TGT_LSB +: 5]; // [RULE6]
  assign guard     = reg_tol[`MDC_GUARD_LSB +: 5];
  assign exact     = reg_tol[`MDC_TOL_BIT];
  assign fail_rst  = reg_tol[`MDC_FAIL_BIT];
  assign start_d   = {reg_dly_hi, reg_dly_lo[`MDC_DLY_LSB_BIT]}; // [RULE4]
  assign dev       = absdiff(phase, target);
  assign hit       = exact ? (dev == 5'h00) : (dev <= `MDC_TOL_LOOSE); // [RULE8]
  assign up_g      = up_d >= `MDC_DELAY_MAX - {4'h0, guard};
  assign dn_g      = dn_d <= {4'h0, guard};

  // register file; readback fields only refresh on a rising read bit
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_boost  <= `MDC_RST_BOOST;
      reg_dcc    <= `MDC_RST_DCC;
      reg_ctrl   <= `MDC_RST_CTRL;
      reg_dly_lo <= `MDC_RST_DLY_LO;
      reg_dly_hi <= `MDC_RST_DLY_HI;
      reg_tol    <= `MDC_RST_TOL_GUARD;
      rb_delay   <= 9'h000;
      rb_phase   <= 5'h00;
      read_q     <= 1'b0;
      boost_level <= 2'h0;
      dcc_enable <= 1'b0;
    end
    else
    begin
      if (wr_stb)
      begin
        case (addr)
          `MDC_OFF_BOOST:     reg_boost  <= wdata;
          `MDC_OFF_DCC:       reg_dcc    <= wdata;
          `MDC_OFF_CTRL:      reg_ctrl   <= wdata;
          `MDC_OFF_DLY_LO:    reg_dly_lo <= wdata;
          `MDC_OFF_DLY_HI:    reg_dly_hi <= wdata;
          `MDC_OFF_TOL_GUARD: reg_tol    <= wdata;
          default:            reg_tol    <= reg_tol;
        endcase
      end
      read_q <= reg_ctrl[`MDC_CTRL_READ_BIT];
      if (reg_ctrl[`MDC_CTRL_READ_BIT] && !read_q)
      begin
        rb_delay <= delay_line_value; // [RULE19]
        rb_phase <= phase;
      end
      boost_level <= reg_boost[`MDC_BOOST_LSB +: 2];
      dcc_enable  <= reg_dcc[`MDC_DCC_BIT];
    end
  end

  always @*
  begin
    case (addr)
      `MDC_OFF_BOOST:     rdata = reg_boost;
      `MDC_OFF_DCC:       rdata = reg_dcc;
      `MDC_OFF_CTRL:      rdata = reg_ctrl;
      `MDC_OFF_DLY_LO:    rdata = reg_ctrl[`MDC_CTRL_READ_BIT] ?
                                  {rb_delay[0], reg_dly_lo[6:5], rb_phase} : reg_dly_lo; // [RULE17]
      `MDC_OFF_DLY_HI:    rdata = reg_ctrl[`MDC_CTRL_READ_BIT] ? rb_delay[8:1] : reg_dly_hi; // [RULE17]
      `MDC_OFF_TOL_GUARD: rdata = reg_tol;
      `MDC_OFF_STATUS:    rdata = {6'h00, delay_lock_lost, delay_locked}; // [RULE15]
      default:            rdata = 8'h00;
    endcase
  end

  // next search step: guard bands narrow the choice, endpoints end it
  always @*
  begin
    can_up = (up_d < `MDC_DELAY_MAX) && (!up_g || dn_g) && (dir != `MDC_DIR_DOWN); // [RULE9] [RULE10]
    can_dn = (dn_d != 9'h000) && (!dn_g || up_g) && (dir != `MDC_DIR_UP); // [RULE9] [RULE10]
    if (dir == `MDC_DIR_UP)
      can_up = up_d < `MDC_DELAY_MAX;
    if (dir == `MDC_DIR_DOWN)
      can_dn = dn_d != 9'h000;
    step_ok = can_up || can_dn; // [RULE11]
    step_up = can_up && (!can_dn || alt);
  end

  task start_search;
    begin
      delay_line_value <= start_d;
      up_d             <= start_d;
      dn_d             <= start_d;
      alt              <= 1'b1;
      restart          <= 1'b1;
      state            <= (mode == `MDC_MODE_TRACK) ? S_TRACK : S_SRCH; // [RULE3] [RULE21]
    end
  endtask

  task take_step;
    begin
      restart <= 1'b1;
      alt     <= ~alt;
      state   <= S_SRCH;
      if (!step_ok)
      begin
        if (fail_rst)
          state <= S_INIT; // [RULE11]
        else
          start_search;
      end
      else if (step_up)
      begin
        up_d             <= up_d + 9'h001;
        delay_line_value <= up_d + 9'h001;
      end
      else
      begin
        dn_d             <= dn_d - 9'h001;
        delay_line_value <= dn_d - 9'h001;
      end
    end
  endtask

  // settle time bounds each step; typical full lock stays near 180K converter cycles [RULE18]
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state            <= S_IDLE;
      delay_line_value <= 9'h000;
      up_d             <= 9'h000;
      dn_d             <= 9'h000;
      center           <= 9'h000;
      p0               <= 5'h00;
      p_up             <= 5'h00;
      alt              <= 1'b0;
      restart          <= 1'b0;
      en_q             <= 1'b0;
      delay_locked     <= 1'b0;
      delay_lock_lost  <= 1'b0;
    end
    else
    begin
      restart <= 1'b0;
      en_q    <= enable;
      if (!enable)
        state <= S_IDLE; // [RULE1] [RULE22]
      else
      begin
        case (state)
          S_IDLE:
          begin
            if (!en_q)
              state <= S_INIT; // [RULE1]
          end
          S_INIT:
          begin
            delay_locked    <= 1'b0;
            delay_lock_lost <= 1'b0;
            start_search;
          end
          S_SRCH:
          begin
            if (phase_valid)
            begin
              if (hit)
              begin
                center  <= delay_line_value; // [RULE7]
                p0      <= phase;
                restart <= 1'b1;
                state   <= S_SUP;
              end
              else
                take_step;
            end
          end
          S_SUP:
          begin
            if (phase_valid)
            begin
              restart <= 1'b1;
              if (absdiff(phase, p0) >= `MDC_SLOPE_DEV || phase == `MDC_PHASE_MAX || phase == 5'h00 ||
                  delay_line_value >= `MDC_SLOPE_DLY_MAX) // [RULE12]
              begin
                p_up             <= phase;
                delay_line_value <= center;
                state            <= S_SDN;
              end
              else
                delay_line_value <= delay_line_value + 9'h001;
            end
          end
          S_SDN:
          begin
            if (phase_valid)
            begin
              restart <= 1'b1;
              if (absdiff(phase, p0) >= `MDC_SLOPE_DEV || phase == `MDC_PHASE_MAX || phase == 5'h00 ||
                  delay_line_value == 9'h000) // [RULE12]
              begin
                if (slope_pos ? (p_up > target && phase < target) : (p_up < target && phase > target)) // [RULE13] [RULE7]
                begin
                  delay_line_value <= center;
                  delay_locked     <= 1'b1;
                  state            <= (mode == `MDC_MODE_SRCH) ? S_HOLD : S_TRACK; // [RULE3]
                end
                else
                  take_step;
              end
              else
                delay_line_value <= delay_line_value - 9'h001;
            end
          end
          S_TRACK:
          begin
            if (phase_valid)
            begin
              restart <= 1'b1;
              if (dev > `MDC_LOCK_DEV)
              begin
                delay_locked <= 1'b0; // [RULE15]
                if (delay_locked)
                begin
                  delay_lock_lost <= 1'b1; // [RULE15]
                  if (fail_rst && mode != `MDC_MODE_TRACK)
                    start_search; // [RULE16]
                end
              end
              else
                delay_locked <= 1'b1;
              // slope is trusted, never remeasured while tracking
              if (phase > target ^ slope_pos)
              begin
                if (delay_line_value < `MDC_DELAY_MAX)
                  delay_line_value <= delay_line_value + 9'h001; // [RULE14]
              end
              else if (phase != target && delay_line_value != 9'h000)
                delay_line_value <= delay_line_value - 9'h001; // [RULE14]
            end
          end
          default:
            state <= S_HOLD; // search-only result stays put
        endcase
      end
    end
  end
endmodule

// ===== bench/mdc_controller_sva.sv
/*
  port-level assertions for the delay phase controller.
  assumes it is bound onto mdc_controller and sees only its ports.
*/
`timescale 1ns/10ps
module mdc_controller_sva #(
  parameter SETTLE_NS = 1000
) (
  input logic       clk,
  input logic       arst_n,
  input logic       spi_sclk,
  input logic       spi_cs_n,
  input logic       spi_sdi,
  input logic       spi_sdo,
  input logic       spi_sdo_oe,
  input logic [4:0] phase_pin,
  input logic [8:0] delay_line_value,
  input logic [1:0] boost_level,
  input logic       dcc_enable,
  input logic       delay_locked,
  input logic       delay_lock_lost
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_DLY_MAX: assert property (delay_line_value <= 9'h1b0)
    else $error("delay above the top endpoint");
  AST_DLY_SETTLE: assert property ($changed(delay_line_value) |=> $stable(delay_line_value) [*4])
    else $error("delay stepped before phase settled");
  AST_TRACK_STEP: assert property ($past(delay_locked) && delay_locked && $changed(delay_line_value)
    |-> (delay_line_value == $past(delay_line_value) + 9'h001) || ($past(delay_line_value) == delay_line_value + 9'h001))
    else $error("tracking step not one");
  AST_LOST_CAUSE: assert property ($rose(delay_lock_lost) |-> $past(delay_locked) && !delay_locked)
    else $error("lost set without losing lock");
  AST_LOST_STICKY: assert property ($fell(delay_lock_lost) |-> !delay_locked)
    else $error("lost cleared outside restart");
  AST_OE_CS: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n)
    else $error("sdo driven while deselected");
  AST_OE_IDLE: assert property (spi_cs_n [*5] |-> !spi_sdo_oe)
    else $error("sdo still driven after deselect");
  AST_CFG_FROM_BUS: assert property ($changed(boost_level) || $changed(dcc_enable) |-> !$past(spi_cs_n, 2))
    else $error("boost or duty copy changed without a write");

  cover property ($rose(delay_locked));
  cover property ($rose(delay_lock_lost));
  cover property ($rose(spi_sdo_oe));
endmodule

bind mdc_controller mdc_controller_sva #(.SETTLE_NS(SETTLE_NS)) mdc_controller_sva_i (
  .clk(clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
  .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .phase_pin(phase_pin), .delay_line_value(delay_line_value),
  .boost_level(boost_level), .dcc_enable(dcc_enable), .delay_locked(delay_locked),
  .delay_lock_lost(delay_lock_lost));

// ===== bench/mdc_controller_bench.sv
/*
  self-checking bench for the delay phase controller.
  assumes a negative-slope delay line model driving phase_pin, serial port at clk/8.
*/
`timescale 1ns/10ps
`include "mdc_regs.vh"
module mdc_controller_bench;
  reg         clk;
  reg         arst_n;
  reg         spi_sclk;
  reg         spi_cs_n;
  reg         spi_sdi;
  reg  [4:0]  phase_pin;
  wire        spi_sdo;
  wire        spi_sdo_oe;
  wire [8:0]  delay_line_value;
  wire [1:0]  boost_level;
  wire        dcc_enable;
  wire        delay_locked;
  wire        delay_lock_lost;
  integer     num_errors;
  integer     comparisons;
  integer     cycles;
  integer     off;
  integer     i;
  reg  [7:0]  rd;
  reg  [8:0]  held;
  reg  [23:0] rows [0:5];

  mdc_controller #(.SETTLE_NS(1000)) mdc_controller_i (
    .clk(clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .phase_pin(phase_pin), .delay_line_value(delay_line_value),
    .boost_level(boost_level), .dcc_enable(dcc_enable), .delay_locked(delay_locked),
    .delay_lock_lost(delay_lock_lost));

  // phase falls four delay steps per count; off shifts it to provoke drift
  function automatic [4:0] pm(input integer d);
    integer p;
    begin
      p = (d < 200) ? 16 : 16 - (d - 200) / 4;
      p = p + off;
      if (p < 0) p = 0;
      if (p > 16) p = 16;
      pm = p[4:0];
    end
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    #1;
    phase_pin = pm(delay_line_value);
  end

  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      num_errors = num_errors + 1;
      results;
    end
  end

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  // one 16-bit frame, each sclk phase four clocks long
  task spi(input [15:0] f);
    integer k;
    begin
      rd = 8'h00;
      spi_cs_n = 1'b0;
      tick(4);
      for (k = 15; k >= 0; k = k - 1)
      begin
        spi_sdi = f[k];
        tick(4);
        if (k < 8) rd[k] = spi_sdo;
        spi_sclk = 1'b1;
        tick(4);
        spi_sclk = 1'b0;
      end
      tick(4);
      spi_cs_n = 1'b1;
      tick(6);
    end
  endtask

  task wr(input [6:0] a, input [7:0] d);
    spi({1'b0, a, d});
  endtask

  task rdr(input [6:0] a);
    spi({1'b1, a, 8'h00});
  endtask

  task chk(input [8:0] got, input [8:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  // bounded wait: 0 locked, 1 lost, 2 delay equal to v
  task wt(input integer sel, input [8:0] v);
    integer n;
    begin
      n = 0;
      while (n < 8000 && !((sel == 0 && delay_locked === 1'b1) || (sel == 1 && delay_lock_lost === 1'b1)
             || (sel == 2 && delay_line_value === v)))
      begin
        tick(1);
        n = n + 1;
      end
      chk({8'h00, n < 8000}, 9'h001);
    end
  endtask

  task done(input [63:0] name);
    $display("test %0s done", name);
  endtask

  task results;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  initial
  begin
    arst_n = 1'b0;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
    phase_pin = 5'h00;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    off = 0;
    rows[0] = {8'h24, 8'h30, 8'h30};
    rows[1] = {8'h25, 8'h80, 8'h80};
    rows[2] = {8'h29, 8'h85, 8'h85};
    rows[3] = {8'h30, 8'h5a, 8'h00};
    rows[4] = {8'h2a, 8'hff, 8'h00};
    rows[5] = {8'h27, 8'ha5, 8'ha5};
    tick(6);
    arst_n = 1'b1;
    tick(2);
    for (i = 0; i < 7; i = i + 1)
    begin
      rdr(`MDC_OFF_BOOST + i);
      chk({1'b0, rd}, 9'h000);
    end
    done("reset");
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(rows[i][22:16], rows[i][15:8]);
      rdr(rows[i][22:16]);
      chk({1'b0, rd}, {1'b0, rows[i][7:0]});
    end
    chk({7'h00, boost_level}, 9'h003);
    chk({8'h00, dcc_enable}, 9'h001);
    done("regs");
    // programmed slope opposite to the line: search must never lock
    wr(`MDC_OFF_DLY_LO, 8'h26);
    wr(`MDC_OFF_DLY_HI, 8'h6c);
    wr(`MDC_OFF_CTRL, 8'h03);
    tick(1500);
    chk({8'h00, delay_locked}, 9'h000);
    done("slope");
    wr(`MDC_OFF_CTRL, 8'h00);
    wr(`MDC_OFF_DLY_LO, 8'h46);
    wr(`MDC_OFF_CTRL, 8'h01);
    for (i = 216; pm(i) != 6; i = i + 1);
    held = i;
    wt(0, 9'h000);
    chk(delay_line_value, held);
    wr(`MDC_OFF_CTRL, 8'h09);
    rdr(`MDC_OFF_DLY_HI);
    chk({1'b0, rd}, {1'b0, held[8:1]});
    rdr(`MDC_OFF_DLY_LO);
    chk({3'h0, rd[7], rd[4:0]}, {3'h0, held[0], 5'h06});
    wr(`MDC_OFF_CTRL, 8'h01);
    rdr(`MDC_OFF_DLY_HI);
    chk({1'b0, rd}, 9'h06c);
    done("search");
    off = 6;
    wt(1, 9'h000);
    for (i = held; pm(i) != 6; i = i + 1);
    wt(2, i);
    chk({7'h00, delay_locked, delay_lock_lost}, 9'h003);
    done("lost");
    wr(`MDC_OFF_CTRL, 8'h00);
    held = delay_line_value;
    off = 0;
    tick(300);
    chk(delay_line_value, held);
    done("disable");
    wr(`MDC_OFF_DLY_LO, 8'h06);
    wr(`MDC_OFF_DLY_HI, 8'h96);
    wr(`MDC_OFF_CTRL, 8'h21);
    for (i = 300; pm(i) != 6; i = i - 1);
    held = i;
    wt(0, 9'h000);
    chk(delay_line_value, held);
    chk({8'h00, delay_lock_lost}, 9'h000);
    off = 3;
    tick(300);
    chk(delay_line_value, held);
    done("srchonly");
    wr(`MDC_OFF_CTRL, 8'h00);
    off = 0;
    wr(`MDC_OFF_DLY_HI, 8'h82);
    wr(`MDC_OFF_CTRL, 8'h11);
    chk({8'h00, delay_line_value > 9'd254}, 9'h001);
    for (i = 260; pm(i) != 6; i = i - 1);
    held = i;
    wt(2, held);
    tick(200);
    chk(delay_line_value, held);
    done("track");
    results;
  end
endmodule
